// ===== dv/source_model.sv
/*
 * model of the reset sources: supply detectors, reset pin, watchdog.
 * assumes the bench calls its tasks from a process tied to clk_i.
 */
module source_model (
	input  wire logic clk_i,
	output logic      power_ok_o,
	output logic      reset_pin_n_o,
	output logic      supply_low_o,
	output logic      watchdog_timeout_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// supply still ramping at start, so power-up is seen
	initial begin
		power_ok_o         = 1'b0;
		reset_pin_n_o      = 1'b1;
		supply_low_o       = 1'b0;
		watchdog_timeout_o = 1'b0;
	end

	task power(input logic v);
		@(posedge clk_i);
		power_ok_o <= v;
	endtask : power

	// pin level; caller holds low past the least width
	task pin(input logic v);
		@(posedge clk_i);
		reset_pin_n_o <= v;
	endtask : pin

	task dip(input logic v);
		@(posedge clk_i);
		supply_low_o <= v;
	endtask : dip

	// one-cycle expiry pulse on clk_i
	task wd;
		@(posedge clk_i);
		watchdog_timeout_o <= 1'b1;
		@(posedge clk_i);
		watchdog_timeout_o <= 1'b0;
	endtask : wd
endmodule : source_model

// ===== dv/tb.sv
/*
 * testbench of the system reset controller: bus tasks, source scenarios.
 * assumes source_model drives all detector, pin and watchdog inputs.
 */
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	reset_ctrl_pkg::fuse_t   fuse = '{2'h1, 4'h0, 1'b0, 3'h0};
	reset_ctrl_pkg::wb_req_t req  = '0;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        power_ok, pin_n, low, wdt, ack, rst_o, bg;
	logic [31:0] dat, q;
	int          n_errors = 0;
	int          checked  = 0;
	int          k;
	logic [3:0]  sel_v = 4'hf;

	always #5 clk_i = ~clk_i;

	source_model src (.clk_i(clk_i), .power_ok_o(power_ok),
		.reset_pin_n_o(pin_n), .supply_low_o(low),
		.watchdog_timeout_o(wdt));

	// short base count keeps stretches at 8 to 64 cycles
	system_reset_controller #(.STARTUP_BASE_CYCLES(4)) uut (
		.clk_i(clk_i), .rst_i(rst_i), .power_ok_i(power_ok),
		.reset_pin_n_i(pin_n), .supply_low_i(low),
		.watchdog_timeout_i(wdt), .fuse_i(fuse), .wb_req_i(req),
		.wb_ack_o(ack), .wb_dat_o(dat), .sys_rst_o(rst_o),
		.bandgap_en_o(bg));

	task summarize;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// one classic cycle; no answer within 20 edges ends the run
	task xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		req <= '{1'b1, 1'b1, we, a, sel_v, d};
		for (i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (ack === 1'b1)
				break;
		end
		if (i == 20) begin
			n_errors++;
			summarize();
		end
		q = dat;
		req <= '0;
	endtask : xfer

	// cycles until the internal reset drops, held to a window
	task settle(input int lo, input int hi);
		int i;
		// look just after the edge, once the reset output has settled
		for (i = 0; i < 2000 && rst_o !== 1'b0; i++) begin
			@(posedge clk_i);
			#1;
		end
		check(32'(i >= lo && i <= hi), 32'h1);
		if (i == 2000)
			summarize();
	endtask : settle

	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1 check(rst_o, 1'b1);
		check(bg, 1'b1);
		src.power(1'b1);
		settle(8, 16);
		xfer(1'b0, 8'h00, '0);
		check(q & 32'h30f, 32'h1);
		xfer(1'b1, 8'h00, '0);
		xfer(1'b0, 8'h00, '0);
		check(q & 32'h30f, 32'h0);
		src.power(1'b0);
		#1 check(rst_o, 1'b1);
		// held low long enough to pass the synchroniser
		repeat (10) @(posedge clk_i);
		src.power(1'b1);
		settle(8, 16);
		xfer(1'b0, 8'h00, '0);
		check(q & 32'h30f, 32'h1);
		xfer(1'b1, 8'h00, '0);
		// pin held low past the least width
		src.pin(1'b0);
		#1 check(rst_o, 1'b1);
		repeat (300) @(posedge clk_i);
		src.pin(1'b1);
		settle(8, 16);
		xfer(1'b0, 8'h00, '0);
		check(q & 32'h30f, 32'h2);
		xfer(1'b1, 8'h00, '0);
		// short dip must be filtered
		src.dip(1'b1);
		repeat (50) @(posedge clk_i);
		src.dip(1'b0);
		repeat (10) @(posedge clk_i);
		check(rst_o, 1'b0);
		src.dip(1'b1);
		repeat (210) @(posedge clk_i);
		check(rst_o, 1'b1);
		xfer(1'b0, 8'h00, '0);
		check(q & 32'h30f, 32'h304);
		src.dip(1'b0);
		settle(8, 16);
		xfer(1'b0, 8'h00, '0);
		check(q & 32'h30f, 32'h4);
		xfer(1'b1, 8'h00, '0);
		// watchdog ignored until reset mode is on
		src.wd();
		repeat (5) @(posedge clk_i);
		check(rst_o, 1'b0);
		xfer(1'b1, 8'h04, 32'h1);
		// lane 0 not selected, so this write must be dropped
		sel_v = 4'he;
		xfer(1'b1, 8'h04, 32'h0);
		sel_v = 4'hf;
		src.wd();
		#1 check(rst_o, 1'b1);
		repeat (5) @(posedge clk_i);
		src.wd();
		settle(8, 12);
		xfer(1'b0, 8'h00, '0);
		check(q & 32'h30f, 32'h8);
		xfer(1'b1, 8'hfb, 32'hffffffff);
		xfer(1'b0, 8'hfb, '0);
		check(q, 32'h0);
		xfer(1'b0, 8'h04, '0);
		check(q & 32'h7, 32'h1);
		// second fuse set: long stretch, monitor off, pin disabled
		fuse <= '{2'h2, 4'hf, 1'b1, 3'h7};
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		settle(64, 72);
		check(bg, 1'b0);
		for (k = 1; k < 4; k++) begin
			xfer(1'b1, 8'h04, 32'(k % 3) << 1);
			repeat (2) @(posedge clk_i);
			check(bg, 32'(k < 3));
		end
		src.pin(1'b0);
		repeat (300) @(posedge clk_i);
		check(rst_o, 1'b0);
		src.pin(1'b1);
		src.dip(1'b1);
		repeat (250) @(posedge clk_i);
		check(rst_o, 1'b0);
		src.dip(1'b0);
		xfer(1'b0, 8'h00, '0);
		check(q & 32'h30f, 32'h1);
		summarize();
	end
endmodule : tb

// ===== rtl/reset_ctrl_pkg.sv
/*
 * constants, field positions and carrier types of the system reset
 * controller. assumes a 100 MHz system clock and a classic wishbone
 * master with 32-bit data.
 */
package reset_ctrl_pkg;

	// clock and filter times
	localparam int CLK_PERIOD_NS = 10;
	localparam int DIP_MIN_NS    = 2000;
	localparam int PIN_MIN_NS    = 2500;
	// least times, rounded up to whole cycles
	localparam int DIP_MIN_CYC =
		(DIP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PIN_MIN_CYC =
		(PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// widths
	localparam int FILT_W = 12;
	localparam int DLY_W  = 24;
	localparam int ADR_W  = 8;
	localparam int DAT_W  = 32;
	localparam int SEL_W  = 4;

	// register offsets (byte addresses)
	localparam logic [ADR_W-1:0] STATUS_OFS  = 8'h00;
	localparam logic [ADR_W-1:0] CONTROL_OFS = 8'h04;

	// status word fields
	localparam int FLAG_POR  = 0;
	localparam int FLAG_PIN  = 1;
	localparam int FLAG_DIP  = 2;
	localparam int FLAG_WD   = 3;
	localparam int FLAG_W    = 4;
	localparam int STAT_BUSY = 8;
	localparam int STAT_DIP  = 9;

	// control word fields
	localparam int CTRL_WD    = 0;
	localparam int CTRL_CMPBG = 1;
	localparam int CTRL_CONV  = 2;
	localparam int CTRL_W     = 3;

	// synchroniser lanes
	localparam int SYN_PWR = 0;
	localparam int SYN_PIN = 1;
	localparam int SYN_DIP = 2;
	localparam int SYN_N   = 3;

	localparam logic [2:0]        DIP_LEVEL_OFF   = 3'h7;
	localparam logic [FLAG_W-1:0] FLAGS_AFTER_POR = 4'h1;
	localparam logic [2:0]        CLOCK_SELECT_FUSE_EXTRA_SH  = 3'h2;
	localparam int                CLOCK_SELECT_FUSE_SLOW_BIT  = 3;

	typedef struct packed {
		logic             cyc;
		logic             stb;
		logic             we;
		logic [ADR_W-1:0] adr;
		logic [SEL_W-1:0] sel;
		logic [DAT_W-1:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic [1:0] startup_time_fuse;
		logic [3:0] clock_select_fuse;
		logic       pin_reset_disable_fuse;
		logic [2:0] supply_monitor_level_fuse;
	} fuse_t;

endpackage : reset_ctrl_pkg

// ===== rtl/system_reset_controller.sv
/*
 * system reset controller: merges power-up, pin, supply dip and
 * watchdog sources into one stretched internal reset, keeps sticky
 * cause flags and drives the bandgap enable.
 * assumes analog detector levels and the pin are asynchronous, the
 * watchdog timeout is a pulse on clk_i, fuses are static.
 */
// The Wishbone slave port and the register offsets were left to the implementer.
module system_reset_controller #(
	parameter int STARTUP_BASE_CYCLES = 1024
) (
	input  wire logic                           clk_i,
	input  wire logic                           rst_i,
	input  wire logic                           power_ok_i,
	input  wire logic                           reset_pin_n_i,
	input  wire logic                           supply_low_i,
	input  wire logic                           watchdog_timeout_i,
	input  wire reset_ctrl_pkg::fuse_t          fuse_i,
	input  wire reset_ctrl_pkg::wb_req_t        wb_req_i,
	output logic                                wb_ack_o,
	output logic [reset_ctrl_pkg::DAT_W-1:0]    wb_dat_o,
	output logic                                sys_rst_o,
	output logic                                bandgap_en_o
);

	typedef struct packed {
		logic [reset_ctrl_pkg::SYN_N-1:0]  s1;
		logic [reset_ctrl_pkg::SYN_N-1:0]  s2;
		logic [reset_ctrl_pkg::SYN_N-1:0]  s3;
		logic [reset_ctrl_pkg::SYN_N-1:0]  lvl;
		logic [reset_ctrl_pkg::FILT_W-1:0] dip_cnt;
		logic                              dip_det;
		logic [reset_ctrl_pkg::FILT_W-1:0] pin_cnt;
		logic                              pin_det;
		logic                              wd_prev;
		logic                              wd_pulse;
		logic                              busy;
		logic [reset_ctrl_pkg::DLY_W-1:0]  dly_cnt;
		logic [reset_ctrl_pkg::FLAG_W-1:0] flags;
		logic [reset_ctrl_pkg::CTRL_W-1:0] ctrl;
		logic                              bg;
		logic                              ack;
		logic [reset_ctrl_pkg::DAT_W-1:0]  rdata;
	} state_t;

	state_t                            st_reg;
	state_t                            st_next;
	logic                              dip_en;
	logic                              pin_en;
	logic                              por_src;
	logic                              any_src;
	logic                              hit;
	logic                              wr;
	logic [2:0]                        dly_shift;
	logic [reset_ctrl_pkg::DLY_W-1:0]  dly_len;
	logic [reset_ctrl_pkg::DAT_W-1:0]  rd;

	assign dip_en = fuse_i.supply_monitor_level_fuse !=
		reset_ctrl_pkg::DIP_LEVEL_OFF;
	assign pin_en = !fuse_i.pin_reset_disable_fuse;
	assign por_src = !st_reg.lvl[reset_ctrl_pkg::SYN_PWR];
	// synchronised view of every source
	assign any_src = por_src | st_reg.pin_det | st_reg.dip_det
		| st_reg.wd_pulse;
	assign hit = wb_req_i.cyc & wb_req_i.stb & !st_reg.ack;
	assign wr  = hit & wb_req_i.we & wb_req_i.sel[0];

	// slow clock selections get a longer settle time
	assign dly_shift = {1'b0, fuse_i.startup_time_fuse}
		+ (fuse_i.clock_select_fuse[reset_ctrl_pkg::CLOCK_SELECT_FUSE_SLOW_BIT]
		? reset_ctrl_pkg::CLOCK_SELECT_FUSE_EXTRA_SH : 3'h0);
	assign dly_len = reset_ctrl_pkg::DLY_W'(STARTUP_BASE_CYCLES)
		<< dly_shift;

	// power and pin assert straight from the pins; dip and watchdog need clock edges
	assign sys_rst_o = !power_ok_i
		| (!reset_pin_n_i & pin_en)
		| st_reg.dip_det
		| st_reg.wd_pulse
		| st_reg.busy;

	assign bandgap_en_o = st_reg.bg;
	assign wb_ack_o     = st_reg.ack;
	assign wb_dat_o     = st_reg.rdata;

	always_comb begin
		rd = '0;
		if (wb_req_i.adr == reset_ctrl_pkg::STATUS_OFS) begin
			rd[reset_ctrl_pkg::FLAG_W-1:0] = st_reg.flags;
			rd[reset_ctrl_pkg::STAT_BUSY]  = st_reg.busy;
			rd[reset_ctrl_pkg::STAT_DIP]   = st_reg.dip_det;
		end else if (wb_req_i.adr == reset_ctrl_pkg::CONTROL_OFS) begin
			rd[reset_ctrl_pkg::CTRL_W-1:0] = st_reg.ctrl;
		end else begin
			rd = '0;
		end
	end

	always_comb begin
		st_next = st_reg;

		// three stages; only the second reads the first
		st_next.s1 = {supply_low_i, reset_pin_n_i, power_ok_i};
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		st_next.lvl = (~(st_reg.s2 ^ st_reg.s3) & st_reg.s3)
			| ((st_reg.s2 ^ st_reg.s3) & st_reg.lvl);

		// supply dip must persist before it counts
		if (dip_en && st_reg.lvl[reset_ctrl_pkg::SYN_DIP]) begin
			if (!st_reg.dip_det) begin
				if (st_reg.dip_cnt == reset_ctrl_pkg::FILT_W'(
					reset_ctrl_pkg::DIP_MIN_CYC - 1)) begin
					st_next.dip_det = 1'b1;
				end else begin
					st_next.dip_cnt = st_reg.dip_cnt + 1'b1;
				end
			end
		end else begin
			st_next.dip_cnt = '0;
			st_next.dip_det = 1'b0;
		end

		// pin low must last the minimum width
		if (pin_en && !st_reg.lvl[reset_ctrl_pkg::SYN_PIN]) begin
			if (!st_reg.pin_det) begin
				if (st_reg.pin_cnt == reset_ctrl_pkg::FILT_W'(
					reset_ctrl_pkg::PIN_MIN_CYC - 1)) begin
					st_next.pin_det = 1'b1;
				end else begin
					st_next.pin_cnt = st_reg.pin_cnt + 1'b1;
				end
			end
		end else begin
			st_next.pin_cnt = '0;
			st_next.pin_det = 1'b0;
		end

		// rising edge only, so a held timeout still gives one cycle
		st_next.wd_prev  = watchdog_timeout_i;
		st_next.wd_pulse = watchdog_timeout_i & !st_reg.wd_prev
			& st_reg.ctrl[reset_ctrl_pkg::CTRL_WD];

		// stretch counter; runs only once all sources are gone
		if (any_src) begin
			st_next.busy    = 1'b1;
			st_next.dly_cnt = '0;
		end else if (st_reg.busy) begin
			if (st_reg.dly_cnt == dly_len - 1'b1) begin
				st_next.busy = 1'b0;
			end else begin
				st_next.dly_cnt = st_reg.dly_cnt + 1'b1;
			end
		end

		// flags: software clears by zero, hardware set wins
		if (wr && wb_req_i.adr == reset_ctrl_pkg::STATUS_OFS) begin
			st_next.flags = st_reg.flags
				& wb_req_i.dat[reset_ctrl_pkg::FLAG_W-1:0];
		end
		if (st_reg.pin_det) begin
			st_next.flags[reset_ctrl_pkg::FLAG_PIN] = 1'b1;
		end
		if (st_reg.dip_det) begin
			st_next.flags[reset_ctrl_pkg::FLAG_DIP] = 1'b1;
		end
		if (st_reg.wd_pulse) begin
			st_next.flags[reset_ctrl_pkg::FLAG_WD] = 1'b1;
		end
		if (por_src) begin
			st_next.flags = reset_ctrl_pkg::FLAGS_AFTER_POR;
		end

		if (wr && wb_req_i.adr == reset_ctrl_pkg::CONTROL_OFS) begin
			st_next.ctrl = wb_req_i.dat[reset_ctrl_pkg::CTRL_W-1:0];
		end

		st_next.bg = dip_en
			| st_reg.ctrl[reset_ctrl_pkg::CTRL_CMPBG]
			| st_reg.ctrl[reset_ctrl_pkg::CTRL_CONV];

		// one wait state; unmapped reads return zero
		st_next.ack = hit;
		if (hit) begin
			st_next.rdata = rd;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg      <= '0;
			st_reg.busy <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_por_async;
		!power_ok_i |-> sys_rst_o;
	endproperty
	a_por_async: assert property (p_por_async)
		else $error("power low without reset");

	property p_pin_async;
		(!reset_pin_n_i && pin_en) |-> sys_rst_o;
	endproperty
	a_pin_async: assert property (p_pin_async)
		else $error("pin low without reset");

	property p_pin_ignored;
		!pin_en |=> !st_reg.pin_det;
	endproperty
	a_pin_ignored: assert property (p_pin_ignored)
		else $error("pin detected while disabled");

	property p_release_len;
		$fell(st_reg.busy) |->
			$past(st_reg.dly_cnt) == $past(dly_len) - 1'b1;
	endproperty
	a_release_len: assert property (p_release_len)
		else $error("stretch ended at wrong count");

	property p_restart;
		any_src |=> (st_reg.busy && st_reg.dly_cnt == '0);
	endproperty
	a_restart: assert property (p_restart)
		else $error("source did not restart delay");

	property p_hold;
		st_reg.busy |-> sys_rst_o;
	endproperty
	a_hold: assert property (p_hold)
		else $error("reset dropped during stretch");

	property p_wd_one;
		st_reg.wd_pulse |=> !st_reg.wd_pulse;
	endproperty
	a_wd_one: assert property (p_wd_one)
		else $error("watchdog pulse longer than one cycle");

	property p_wd_mode;
		!st_reg.ctrl[reset_ctrl_pkg::CTRL_WD] |=> !st_reg.wd_pulse;
	endproperty
	a_wd_mode: assert property (p_wd_mode)
		else $error("watchdog reset while mode off");

	sequence s_wd_end;
		st_reg.wd_pulse ##1 !st_reg.wd_pulse;
	endsequence
	property p_wd_stretch;
		s_wd_end |-> (st_reg.busy && st_reg.dly_cnt == '0);
	endproperty
	a_wd_stretch: assert property (p_wd_stretch)
		else $error("watchdog pulse end did not start delay");

	property p_dip_filter;
		$rose(st_reg.dip_det) |-> $past(st_reg.dip_cnt) ==
			reset_ctrl_pkg::FILT_W'(reset_ctrl_pkg::DIP_MIN_CYC - 1);
	endproperty
	a_dip_filter: assert property (p_dip_filter)
		else $error("dip detected before minimum time");

	property p_pin_release;
		$fell(st_reg.pin_det) |-> st_reg.busy;
	endproperty
	a_pin_release: assert property (p_pin_release)
		else $error("pin release skipped the delay");

	property p_bandgap;
		!rst_i |=> bandgap_en_o == $past(dip_en
			| st_reg.ctrl[reset_ctrl_pkg::CTRL_CMPBG]
			| st_reg.ctrl[reset_ctrl_pkg::CTRL_CONV]);
	endproperty
	a_bandgap: assert property (p_bandgap)
		else $error("bandgap enable wrong");

	property p_flag_wd;
		(st_reg.wd_pulse && !por_src) |=>
			st_reg.flags[reset_ctrl_pkg::FLAG_WD];
	endproperty
	a_flag_wd: assert property (p_flag_wd)
		else $error("watchdog flag not set");

	property p_flag_por;
		(!rst_i && por_src) |=>
			st_reg.flags == reset_ctrl_pkg::FLAGS_AFTER_POR;
	endproperty
	a_flag_por: assert property (p_flag_por)
		else $error("power-up flags wrong");

	property p_dip_now;
		st_reg.dip_det |-> sys_rst_o;
	endproperty
	a_dip_now: assert property (p_dip_now)
		else $error("dip detected without reset");

endmodule : system_reset_controller
